// file: signal_mux_map.vh
`ifndef SIGNAL_MUX_MAP_VH
`define SIGNAL_MUX_MAP_VH
`define SD_BASE 24'h000200
`define SD_SPAN_MASK 24'hffff00
`define OFS_SEL_LAST 8'h40
`define OFS_PERIOD 8'h80
`define OFS_LOW 8'h84
`define OFS_COUNT 8'h88
`define OFS_LAUNCH 8'h8c
`define OFS_STATUS 8'h90
`define SEL_W 5
`define NUM_OUTPUTS 17
`define SRC_LOW 5'h00
`define SRC_HIGH 5'h01
`define SRC_SYNC 5'h02
`define SRC_ACCEPT_TRIGGER_ONE 5'h03
`define SRC_ACCEPT_TRIGGER_TWO 5'h04
`define SRC_FP_IN 5'h05
`define SRC_P2_IN 5'h0a
`define SRC_PULSER 5'h12
`define SRC_BUSY 5'h13
`define SRC_FW_TRIG 5'h14
`define SRC_LAST 5'h1b
`define COUNT_OFF 32'h00000000
`define COUNT_FOREVER 32'hffffffff
`define AM_A24_DATA 6'h39
`define AM_A24_DATA_SUP 6'h3d
`define ZERO32 32'h00000000
`endif

// file: source_select.v
`timescale 1ns/1ps
`default_nettype none
`include "signal_mux_map.vh"
module source_select (
  input wire [4:0] source_code,
  input wire [27:0] sources,
  output wire routed
);
  // undefined codes fall to zero so a bad write cannot toggle a line
  assign routed = (source_code > `SRC_LAST) ? 1'b0 :
                  sources[source_code]; // R5 R6 R7 R16
endmodule
`default_nettype wire

// file: pulse_generator.v
`timescale 1ns/1ps
`default_nettype none
`include "signal_mux_map.vh"
module pulse_generator (
  input wire core_clk,
  input wire rst,
  input wire [31:0] period_ticks,
  input wire [31:0] low_ticks,
  input wire [31:0] burst_count,
  input wire launch,
  output reg pulse_out,
  output reg finished
);
  reg [31:0] tick_reg;
  reg [31:0] done_reg;
  reg running_reg;
  wire forever_mode = (burst_count == `COUNT_FOREVER);
  wire disabled = (burst_count == `COUNT_OFF);
  wire last_tick = (tick_reg + 32'h00000001 >= period_ticks);
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_reg <= `ZERO32;
      done_reg <= `ZERO32;
      running_reg <= 1'b0;
      pulse_out <= 1'b0;
      finished <= 1'b1;
    end else begin
      if (disabled) begin
        running_reg <= 1'b0; // R10
        tick_reg <= `ZERO32;
      end else if (launch) begin
        running_reg <= 1'b1; // R13 R14
        tick_reg <= `ZERO32;
        done_reg <= `ZERO32; // R14
      end else if (running_reg || forever_mode) begin
        // one tick per clock cycle at the 4 ns system rate
        if (last_tick) begin
          tick_reg <= `ZERO32; // R8
          if (!forever_mode) begin
            done_reg <= done_reg + 32'h00000001;
            if (done_reg + 32'h00000001 >= burst_count)
              running_reg <= 1'b0; // R11
          end
        end else begin
          tick_reg <= tick_reg + 32'h00000001; // R17
        end
      end
      pulse_out <= !disabled && (running_reg || forever_mode) &&
                   (tick_reg >= low_ticks); // R9 R12
      finished <= disabled || !(running_reg || forever_mode); // R15
    end
  end
endmodule
`default_nettype wire

// file: signal_mux_pulser.v
`timescale 1ns/1ps
`default_nettype none
`include "signal_mux_map.vh"
// Operation
// R1 - registers use single A24 32-bit cycles
// R2 - group decoded at base 0x0200
// R3 - one select word per output
// R4 - output index order fixed by board
// R5 - codes 0/1 give constant low/high
// R6 - codes 2..17 pick backplane/front inputs
// R7 - codes 18..27 pick pulser, busy, triggers
// R8 - period counts 4 ns ticks
// R9 - low for low ticks, high after
// R10 - zero count disables the pulser
// R11 - finite count gives that many periods
// R12 - all ones runs forever
// R13 - fixed bursts wait for launch write
// R14 - launch write starts, clears delivered count
// R15 - status bit 0 reads done
// R16 - undefined codes drive low
// R17 - one tick per clock, zero reset
module signal_mux_pulser (
  input wire core_clk,
  input wire rst,
  input wire [23:0] bus_addr,
  input wire [5:0] bus_am,
  input wire bus_strobe,
  input wire bus_write,
  input wire bus_lword_n,
  input wire [31:0] bus_wdata,
  output reg [31:0] bus_rdata,
  output reg bus_ack,
  output reg bus_err,
  input wire sync_in,
  input wire accept_trigger_one,
  input wire accept_trigger_two,
  input wire [4:0] front_in,
  input wire [7:0] p2_in,
  input wire builder_busy,
  input wire [7:0] fw_trigger,
  output reg [4:0] front_out,
  output reg [1:0] nim_out,
  output reg [7:0] p2_out,
  output reg internal_trigger_output,
  output reg internal_sync_output,
  output reg pulse_finished_bit
);
  reg [4:0] output_source_select [0:16];
  reg [31:0] pulse_period_ticks;
  reg [31:0] pulse_low_ticks;
  reg [31:0] pulse_burst_count;
  reg launch_reg;
  wire pulser_out;
  wire pulser_done;
  wire [27:0] sources;
  wire [16:0] routed;
  integer i;

  // block modes are refused: only plain data address modifiers answer
  wire am_ok = (bus_am == `AM_A24_DATA) || (bus_am == `AM_A24_DATA_SUP);
  wire in_group = ((bus_addr & `SD_SPAN_MASK) == `SD_BASE); // R2
  wire aligned = (bus_addr[1:0] == 2'b00) && !bus_lword_n; // R1
  wire [7:0] ofs = bus_addr[7:0];
  wire hit = bus_strobe && am_ok && in_group && aligned; // R1
  // the last select word sits at 0x40, so the bound is inclusive
  wire sel_hit = (ofs <= `OFS_SEL_LAST); // R3
  wire [4:0] sel_idx = ofs[6:2];
  wire known = sel_hit || ofs == `OFS_PERIOD || ofs == `OFS_LOW ||
               ofs == `OFS_COUNT || ofs == `OFS_LAUNCH ||
               ofs == `OFS_STATUS;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 17; i = i + 1)
        output_source_select[i] <= `SRC_LOW; // R17
      pulse_period_ticks <= `ZERO32;
      pulse_low_ticks <= `ZERO32;
      pulse_burst_count <= `ZERO32;
      launch_reg <= 1'b0;
      bus_rdata <= `ZERO32;
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
    end else begin
      launch_reg <= 1'b0;
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
      // strobe is taken for one cycle per access; master drops it after ack
      if (hit && !bus_ack && !bus_err) begin
        bus_ack <= known;
        bus_err <= !known;
        bus_rdata <= `ZERO32;
        if (bus_write) begin
          if (sel_hit)
            output_source_select[sel_idx] <= bus_wdata[4:0]; // R3
          if (ofs == `OFS_PERIOD)
            pulse_period_ticks <= bus_wdata; // R8
          if (ofs == `OFS_LOW)
            pulse_low_ticks <= bus_wdata; // R9
          if (ofs == `OFS_COUNT)
            pulse_burst_count <= bus_wdata;
          if (ofs == `OFS_LAUNCH)
            launch_reg <= 1'b1; // R14
        end else begin
          if (sel_hit)
            bus_rdata <= {27'h0000000, output_source_select[sel_idx]};
          if (ofs == `OFS_PERIOD)
            bus_rdata <= pulse_period_ticks;
          if (ofs == `OFS_LOW)
            bus_rdata <= pulse_low_ticks;
          if (ofs == `OFS_COUNT)
            bus_rdata <= pulse_burst_count;
          if (ofs == `OFS_STATUS)
            bus_rdata <= {31'h00000000, pulser_done}; // R15
        end
      end
    end
  end

  pulse_generator pulser (
    .core_clk(core_clk),
    .rst(rst),
    .period_ticks(pulse_period_ticks),
    .low_ticks(pulse_low_ticks),
    .burst_count(pulse_burst_count),
    .launch(launch_reg),
    .pulse_out(pulser_out),
    .finished(pulser_done)
  );

  assign sources = {fw_trigger, builder_busy, pulser_out, p2_in, front_in,
                    accept_trigger_two, accept_trigger_one, sync_in,
                    1'b1, 1'b0}; // R6 R7

  genvar g;
  generate
    for (g = 0; g < 17; g = g + 1) begin : route
      source_select mux (
        .source_code(output_source_select[g]),
        .sources(sources),
        .routed(routed[g])
      );
    end
  endgenerate

  // registered outputs add one cycle of latency to every routed line
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      front_out <= 5'h00;
      nim_out <= 2'h0;
      p2_out <= 8'h00;
      internal_trigger_output <= 1'b0;
      internal_sync_output <= 1'b0;
      pulse_finished_bit <= 1'b1;
    end else begin
      front_out <= routed[4:0]; // R4
      nim_out <= routed[6:5]; // R4
      p2_out <= routed[14:7]; // R4
      internal_trigger_output <= routed[15]; // R4
      internal_sync_output <= routed[16]; // R4
      pulse_finished_bit <= pulser_done;
    end
  end
endmodule
`default_nettype wire

// file: mux_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mux_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [23:0] bus_addr,
  input wire logic [5:0] bus_am,
  input wire logic bus_strobe,
  input wire logic bus_lword_n,
  input wire logic bus_ack,
  input wire logic bus_err,
  input wire logic pulse_finished_bit
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic am_ok = bus_am == 6'h39 || bus_am == 6'h3d;
  wire logic grp = bus_addr[23:8] == 16'h0002;
  wire logic ok = am_ok && grp && bus_addr[1:0] == 2'b00 && !bus_lword_n;
  ack_pulse_a:
    assert property (bus_ack |=> !bus_ack) else $error("ack held");
  err_pulse_a:
    assert property (bus_err |=> !bus_err) else $error("err held");
  one_answer_a:
    assert property (!(bus_ack && bus_err)) else $error("ack with err");
  take_answer_a:
    assert property (bus_strobe && !$past(bus_strobe) && ok
      |=> bus_ack || bus_err) else $error("request unanswered");
  bad_am_a:
    assert property (bus_strobe && !$past(bus_strobe) && !am_ok
      |=> (!bus_ack && !bus_err)[*3]) else $error("wrong am answered");
  misalign_quiet_a:
    assert property (bus_strobe && !$past(bus_strobe) && bus_addr[1:0] != 0
      |=> !bus_ack && !bus_err) else $error("misaligned answered");
  other_base_a:
    assert property (bus_strobe && !$past(bus_strobe) && !grp
      |=> !(bus_ack || bus_err)) else $error("other base answered");
  launch_status_a:
    assert property ($fell(pulse_finished_bit)
      |-> $past(bus_ack, 2) || $past(bus_ack, 3)) else $error("status fell");
endmodule
bind signal_mux_pulser mux_chk mux_chk_inst (.core_clk(core_clk),
  .rst(rst), .bus_addr(bus_addr), .bus_am(bus_am), .bus_strobe(bus_strobe),
  .bus_lword_n(bus_lword_n), .bus_ack(bus_ack), .bus_err(bus_err),
  .pulse_finished_bit(pulse_finished_bit));
`default_nettype wire

// file: line_drv.sv
`timescale 1ns/1ps
`default_nettype none
module line_drv (
  input wire logic core_clk,
  output var logic [24:0] lines
);
  // lfsr keeps every line moving, so a wrong route shows quickly
  initial lines = 25'h0a5f3c1;
  always @(negedge core_clk) lines <= {lines[23:0], lines[24] ^ lines[21]};
endmodule
`default_nettype wire

// file: tb_signal_mux_pulser.sv
`timescale 1ns/1ps
`default_nettype none
module tb_signal_mux_pulser;
  logic core_clk = 0, rst = 1, bus_strobe = 0, bus_write = 0;
  logic bus_lword_n = 0, bus_ack, bus_err, pulse_finished_bit, itrig, isync;
  logic [23:0] bus_addr = 24'h000000;
  logic [5:0] bus_am = 6'h39;
  logic [31:0] bus_wdata = 32'h00000000, bus_rdata, q;
  logic [4:0] front_out;
  logic [1:0] nim_out, r;
  logic [7:0] p2_out;
  logic [24:0] lines;
  logic [29:0] bad [4] = '{{24'h000244, 6'h39}, {24'h000202, 6'h39},
    {24'h000300, 6'h39}, {24'h000200, 6'h09}};
  int n_mismatch = 0, n_compared = 0, n_hi = 0;
  wire logic [31:0] src = {4'h0, lines[24:16], 1'b0, lines[15:0], 2'b10};
  wire logic [16:0] outs = {isync, itrig, p2_out, nim_out, front_out};
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (front_out[0] === 1'b1) n_hi <= n_hi + 1;
  line_drv line_drv_inst (.core_clk(core_clk), .lines(lines));
  signal_mux_pulser signal_mux_pulser_inst (.core_clk(core_clk), .rst(rst),
    .bus_addr(bus_addr), .bus_am(bus_am), .bus_strobe(bus_strobe),
    .bus_write(bus_write), .bus_lword_n(bus_lword_n), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err),
    .sync_in(lines[0]), .accept_trigger_one(lines[1]),
    .accept_trigger_two(lines[2]), .front_in(lines[7:3]),
    .p2_in(lines[15:8]), .builder_busy(lines[16]), .fw_trigger(lines[24:17]),
    .front_out(front_out), .nim_out(nim_out), .p2_out(p2_out),
    .internal_trigger_output(itrig), .internal_sync_output(isync),
    .pulse_finished_bit(pulse_finished_bit));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [23:0] a, input logic w,
      input logic [31:0] d, input logic [5:0] am);
    r = 2'b00;
    @(negedge core_clk);
    {bus_addr, bus_write, bus_wdata, bus_am, bus_strobe} = {a, w, d, am, 1'b1};
    // a refused request gets no answer, so the wait is bounded
    repeat (4) if (r == 2'b00) begin
      @(negedge core_clk);
      r = {bus_err, bus_ack};
      q = bus_rdata;
    end
    @(posedge core_clk);
    @(negedge core_clk);
    bus_strobe = 0;
  endtask
  task automatic rd(input logic [23:0] a, input logic [31:0] e);
    bus(a, 0, 32'h00000000, 6'h39);
    chk(q, e);
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    bus(a, 1, d, 6'h39);
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #50000;
    n_mismatch++;
    conclude;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) rst = 0;
    rd(24'h000200, 32'h00000000);
    rd(24'h000290, 32'h00000001);
    $display("reset test done");
    foreach (bad[i]) begin
      bus(bad[i][29:6], 0, 32'h00000000, bad[i][5:0]);
      chk({30'h0, r}, {30'h0, i == 0 ? 2'b10 : 2'b00});
    end
    $display("refusal test done");
    for (int c = 0; c < 32; c++) begin
      wr(24'h000200 + 24'(4 * (c % 17)), 32'(c));
      repeat (3) begin
        @(posedge core_clk);
        #1 chk({31'h0, outs[c % 17]}, {31'h0, src[c]});
      end
    end
    rd(24'h000204, 32'h00000012);
    $display("routing test done");
    wr(24'h000200, 32'h00000012);
    wr(24'h000280, 32'h00000005);
    wr(24'h000284, 32'h00000002);
    wr(24'h000288, 32'h00000002);
    rd(24'h000280, 32'h00000005);
    n_hi = 0;
    repeat (10) @(negedge core_clk);
    chk(32'(n_hi), 32'h00000000);
    wr(24'h00028c, 32'h00000000);
    n_hi = 0;
    rd(24'h000290, 32'h00000000);
    repeat (30) @(negedge core_clk);
    chk(32'(n_hi), 32'h00000006);
    rd(24'h000290, 32'h00000001);
    chk({31'h0, pulse_finished_bit}, 32'h00000001);
    wr(24'h000288, 32'hffffffff);
    repeat (5) @(negedge core_clk);
    n_hi = 0;
    repeat (40) @(negedge core_clk);
    chk(32'(n_hi), 32'h00000018);
    rd(24'h000290, 32'h00000000);
    wr(24'h000288, 32'h00000000);
    repeat (3) @(negedge core_clk);
    n_hi = 0;
    repeat (20) @(negedge core_clk);
    chk(32'(n_hi), 32'h00000000);
    rd(24'h000290, 32'h00000001);
    $display("pulser test done");
    conclude;
  end
endmodule
`default_nettype wire
